// ===== hdl/cstm_ctrl.v
// changer stage lift and tray motor controller
// assumes a 10 MHz ref_clk_i, pin inputs asynchronous, position values from an external ADC
// Summary of operation
// - after clamp and tray stop, drive down 240 ms
// - during retraction hold stage at stored target
// - retract only after tray reaches prescribed position
// - driver lines one and three always equal
// - three-line codes select lift and tray actions
// - lift forward raises stage; tray forward ejects
// - detect disc only while tray pulls out
// - sense low below threshold, high otherwise
// - window low if any low sample seen
// - move stage until position voltage matches target
`timescale 1ns/1ps
`include "cstm_consts.vh"

module cstm_ctrl #(
	parameter POS_W     = 10,
	parameter NUDGE_CYC = `CSTM_NUDGE_CYC,
	parameter POS_TOL   = 2
) (
	// clock and reset
	input  wire             ref_clk_i,
	input  wire             srst_i,
	// commands
	input  wire             elevate_req_i,
	input  wire [POS_W-1:0] target_pos_i,
	input  wire             eject_req_i,
	// sensors (pins)
	input  wire [POS_W-1:0] stage_position_voltage_i,
	input  wire             clamp_done_i,
	input  wire             tray_stopped_i,
	input  wire             tray_in_place_i,
	input  wire             tray_home_i,
	input  wire             disc_sense_i,
	input  wire             win_a_i,
	input  wire             win_b_i,
	// driver
	output reg              driver_ctrl_line_one_o,
	output reg              driver_ctrl_line_two_o,
	output reg              driver_ctrl_line_three_o,
	output reg              driver_ctrl_line_four_o,
	// status
	output wire             busy_o,
	output reg  [1:0]       disc_class_ff_o
);
	// ****************************************************************
	// states
	// ****************************************************************
	localparam [6:0] ST_IDLE    = 7'h01;
	localparam [6:0] ST_ELEV    = 7'h02;
	localparam [6:0] ST_EXTRACT = 7'h04;
	localparam [6:0] ST_CLAMP   = 7'h08;
	localparam [6:0] ST_NUDGE   = 7'h10;
	localparam [6:0] ST_RETRACT = 7'h20;
	localparam [6:0] ST_PLAY    = 7'h40;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	reg [POS_W-1:0] pos_s1_ff, pos_ff;
	reg [6:0]       pin_s1_ff, pin_ff;
	wire            clamp_done, tray_stopped, tray_in_place, tray_home, sense_hi, win_a, win_b;

	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			pos_s1_ff <= {POS_W{1'b0}};
			pos_ff    <= {POS_W{1'b0}};
			pin_s1_ff <= 7'h00;
			pin_ff    <= 7'h00;
		end else begin
			// the multi-bit value is double-flopped with no check that the ADC result holds still
			pos_s1_ff <= stage_position_voltage_i;
			pos_ff    <= pos_s1_ff;
			pin_s1_ff <= {clamp_done_i, tray_stopped_i, tray_in_place_i, tray_home_i,
			              disc_sense_i, win_a_i, win_b_i};
			pin_ff    <= pin_s1_ff;
		end
	end
	// comparator sits outside: high means at or above 2.5 V, light blocked
	assign {clamp_done, tray_stopped, tray_in_place, tray_home, sense_hi, win_a, win_b}
	       = pin_ff;

	// ****************************************************************
	// position comparison
	// ****************************************************************
	function [1:0] pos_cmp; // {below, above}, zero inside band
		input [POS_W-1:0] cur;
		input [POS_W-1:0] tgt;
		begin
			if ({1'b0, cur} + POS_TOL < {1'b0, tgt}) begin
				pos_cmp = 2'h2;
			end else if ({1'b0, tgt} + POS_TOL < {1'b0, cur}) begin
				pos_cmp = 2'h1;
			end else begin
				pos_cmp = 2'h0;
			end
		end
	endfunction

	// ****************************************************************
	// sequencer
	// ****************************************************************
	reg [6:0]       state_ff, nxt_state;
	reg [POS_W-1:0] target_ff, nxt_target;
	reg [21:0]      nudge_cnt_ff, nxt_nudge_cnt;
	reg [2:0]       code;
	reg             retr_go_ff, nxt_retr_go;
	wire [1:0]      cmp;
	wire            win_a_low, win_b_low;

	assign cmp    = pos_cmp(pos_ff, target_ff);
	assign busy_o = (state_ff != ST_IDLE) && (state_ff != ST_PLAY);

	always @* begin
		nxt_state     = state_ff;
		nxt_target    = target_ff;
		nxt_nudge_cnt = nudge_cnt_ff;
		nxt_retr_go   = retr_go_ff;
		code          = `CSTM_CODE_STANDBY;
		case (state_ff)
			ST_IDLE, ST_PLAY: begin
				nxt_retr_go = 1'b0;
				if (elevate_req_i) begin
					nxt_target = target_pos_i;
					nxt_state  = ST_ELEV;
				end else if (eject_req_i && state_ff == ST_PLAY) begin
					nxt_state = ST_RETRACT;
				end
			end
			ST_ELEV: begin
				// lift forward raises the stage toward lower disc numbers
				if (cmp == 2'h2) begin
					code = `CSTM_CODE_LIFT_FWD;
				end else if (cmp == 2'h1) begin
					code = `CSTM_CODE_LIFT_REV;
				end else begin
					nxt_state = ST_EXTRACT;
				end
			end
			ST_EXTRACT: begin
				code = `CSTM_CODE_TRAY_REV;
				if (tray_in_place) begin
					nxt_state = ST_CLAMP;
				end
			end
			ST_CLAMP: begin
				// brake the tray until the clamp is done and it has fully stopped
				code = `CSTM_CODE_BRAKE;
				if (clamp_done && tray_stopped) begin
					nxt_nudge_cnt = 22'h000000;
					nxt_state     = ST_NUDGE;
				end
			end
			ST_NUDGE: begin
				// timed, not position limited: the stage is pressed against its stop
				code          = `CSTM_CODE_LIFT_REV;
				nxt_nudge_cnt = nudge_cnt_ff + 22'h000001;
				if (nudge_cnt_ff == NUDGE_CYC - 1) begin
					nxt_state = ST_PLAY;
				end
			end
			ST_RETRACT: begin
				// tray forward ejects it back into the magazine slot
				// start is latched: a moving tray leaves the prescribed position at once
				if (!retr_go_ff && !tray_in_place && !tray_home) begin
					code = `CSTM_CODE_STANDBY;
				end else if (tray_home) begin
					nxt_retr_go = 1'b0;
					nxt_state   = ST_IDLE;
				end else if (cmp == 2'h2) begin
					nxt_retr_go = 1'b1;
					code        = `CSTM_CODE_LIFT_FWD;
				end else if (cmp == 2'h1) begin
					nxt_retr_go = 1'b1;
					code        = `CSTM_CODE_LIFT_REV;
				end else begin
					nxt_retr_go = 1'b1;
					code        = `CSTM_CODE_TRAY_FWD;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_ff                 <= ST_IDLE;
			target_ff                <= {POS_W{1'b0}};
			nudge_cnt_ff             <= 22'h000000;
			retr_go_ff               <= 1'b0;
			driver_ctrl_line_one_o   <= 1'b0;
			driver_ctrl_line_two_o   <= 1'b0;
			driver_ctrl_line_three_o <= 1'b0;
			driver_ctrl_line_four_o  <= 1'b0;
		end else begin
			state_ff                 <= nxt_state;
			target_ff                <= nxt_target;
			nudge_cnt_ff             <= nxt_nudge_cnt;
			retr_go_ff               <= nxt_retr_go;
			driver_ctrl_line_one_o   <= code[2];
			driver_ctrl_line_three_o <= code[2];
			driver_ctrl_line_two_o   <= code[1];
			driver_ctrl_line_four_o  <= code[0];
		end
	end

	// ****************************************************************
	// disc detection
	// ****************************************************************
	wire extracting = (state_ff == ST_EXTRACT);
	reg  prev_b_ff;

	cstm_window_sampler u_win_a (
		.ref_clk_i    (ref_clk_i),
		.srst_i       (srst_i),
		.win_open_i   (extracting && win_a),
		.sense_i      (sense_hi),
		.win_start_i  (elevate_req_i),
		.win_low_ff_o (win_a_low)
	);

	cstm_window_sampler u_win_b (
		.ref_clk_i    (ref_clk_i),
		.srst_i       (srst_i),
		.win_open_i   (extracting && win_b),
		.sense_i      (sense_hi),
		.win_start_i  (elevate_req_i),
		.win_low_ff_o (win_b_low)
	);

	// classify when window B closes during extraction
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			prev_b_ff       <= 1'b0;
			disc_class_ff_o <= `CSTM_DISC_UNKNOWN;
		end else begin
			prev_b_ff <= extracting && win_b;
			if (elevate_req_i) begin
				disc_class_ff_o <= `CSTM_DISC_UNKNOWN;
			end else if (prev_b_ff && !(extracting && win_b)) begin
				disc_class_ff_o <= (win_a_low && !win_b_low) ? `CSTM_DISC_8CM
				                                             : `CSTM_DISC_NONE_OR_12;
			end
		end
	end
endmodule

// ===== hdl/cstm_consts.vh
// constants for the changer stage and tray motor controller
// assumes a 10 MHz ref_clk_i; included by the controller and its window sampler
`ifndef CSTM_CONSTS_VH
`define CSTM_CONSTS_VH

// ****************************************************************
// timing
// ****************************************************************
`define CSTM_CLK_HZ          10000000
`define CSTM_NUDGE_MS        240
// per-ms factor truncates, no round-up: 240 ms at 10 MHz = 2400000 cycles
`define CSTM_NUDGE_CYC       ((`CSTM_NUDGE_MS * (`CSTM_CLK_HZ / 1000)) + 0)

// ****************************************************************
// driver codes {line 1/3, line 2, line 4}
// ****************************************************************
`define CSTM_CODE_LIFT_FWD   3'h6
`define CSTM_CODE_LIFT_REV   3'h1
`define CSTM_CODE_TRAY_FWD   3'h5
`define CSTM_CODE_TRAY_REV   3'h2
`define CSTM_CODE_BRAKE      3'h7
`define CSTM_CODE_STANDBY    3'h0

// ****************************************************************
// disc classes
// ****************************************************************
`define CSTM_DISC_NONE_OR_12 2'h0
`define CSTM_DISC_8CM        2'h1
`define CSTM_DISC_UNKNOWN    2'h2

`endif

// ===== hdl/cstm_window_sampler.v
// window sampler: records whether the sense line was ever low in a window
// assumes sense_i is already synchronised to ref_clk_i
`timescale 1ns/1ps
`include "cstm_consts.vh"

module cstm_window_sampler (
	// clock and reset
	input  wire ref_clk_i,
	input  wire srst_i,
	// sampling
	input  wire win_open_i,
	input  wire sense_i,
	input  wire win_start_i,
	// result
	output reg  win_low_ff_o
);
	// ****************************************************************
	// sticky low detector
	// ****************************************************************
	reg nxt_win_low;

	always @* begin
		nxt_win_low = win_low_ff_o;
		if (win_start_i) begin
			nxt_win_low = 1'b0;
		end
		if (win_open_i && !sense_i) begin
			nxt_win_low = 1'b1;
		end
	end

	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			win_low_ff_o <= 1'b0;
		end else begin
			win_low_ff_o <= nxt_win_low;
		end
	end
endmodule

// ===== verification/cstm_motor_model.sv
// model of the motor driver, stage position pot and tray switches
// assumes code_i is {line 1/3, line 2, line 4} from the controller
`timescale 1ns/1ps
module cstm_motor_model (
	input  wire       ref_clk_i,
	input  wire       srst_i,
	input  wire [2:0] code_i,
	output reg  [9:0] pos_o,
	output reg        clamp_o,
	output reg        stop_o,
	output wire       in_place_o,
	output wire       home_o
);
	reg [4:0] tray_ff;
	reg [1:0] brk_ff;
	assign in_place_o = tray_ff == 5'h1F;
	assign home_o     = tray_ff == 5'h00;
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			pos_o <= 10'h200;
			tray_ff <= 5'h00;
		end else begin
			// lift forward raises the pot value, tray reverse pulls the tray out
			if (code_i == 3'h6) pos_o <= pos_o + 10'h001;
			if (code_i == 3'h1) pos_o <= pos_o - 10'h001;
			if (code_i == 3'h2 && !in_place_o) tray_ff <= tray_ff + 5'h01;
			if (code_i == 3'h5 && !home_o) tray_ff <= tray_ff - 5'h01;
		end
		// clamp completes only after the brake code has held a while
		brk_ff <= (code_i == 3'h7) ? {brk_ff[0], 1'b1} : 2'h0;
		clamp_o <= !srst_i && brk_ff == 2'h3;
		stop_o <= code_i != 3'h2 && code_i != 3'h5;
	end
endmodule

// ===== verification/cstm_ctrl_properties.sv
// checker for the stage lift and tray motor controller
// assumes it is bound onto cstm_ctrl; one clock domain
`timescale 1ns/1ps
module cstm_ctrl_props #(
	parameter NUDGE_CYC = 20
) (
	input wire       ref_clk_i,
	input wire       srst_i,
	input wire       elevate_req_i,
	input wire       clamp_done_i,
	input wire       tray_stopped_i,
	input wire       win_b_i,
	input wire       driver_ctrl_line_one_o,
	input wire       driver_ctrl_line_two_o,
	input wire       driver_ctrl_line_three_o,
	input wire       driver_ctrl_line_four_o,
	input wire       busy_o,
	input wire [1:0] disc_class_ff_o
);
	wire [2:0] code = {driver_ctrl_line_one_o, driver_ctrl_line_two_o, driver_ctrl_line_four_o};
	reg [2:0]  prev_ff;
	reg        nrun_ff;
	reg [31:0] ncnt_ff;
	// counts a lift-reverse run that starts straight out of the clamp brake
	always @(posedge ref_clk_i) begin
		prev_ff <= code;
		if (!srst_i && code == 3'h1 && (nrun_ff || prev_ff == 3'h7)) begin
			nrun_ff <= 1'b1;
			ncnt_ff <= ncnt_ff + 32'h1;
		end else begin
			nrun_ff <= 1'b0;
			ncnt_ff <= 32'h0;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	lines_same_a: assert property (driver_ctrl_line_one_o == driver_ctrl_line_three_o)
		else $error("lines one and three differ");
	code_legal_a: assert property (code != 3'h3 && code != 3'h4)
		else $error("undefined driver code");
	reset_idle_a: assert property ($fell(srst_i) |-> code == 3'h0 && !busy_o)
		else $error("not standby after reset");
	nudge_start_a: assert property (clamp_done_i && tray_stopped_i && code == 3'h7
		|-> ##[1:6] code == 3'h1) else $error("nudge did not start");
	nudge_len_a: assert property (nrun_ff && code != 3'h1 |-> ncnt_ff == NUDGE_CYC && code == 3'h0)
		else $error("nudge length wrong");
	busy_take_a: assert property (elevate_req_i && !busy_o |=> busy_o)
		else $error("elevate request not taken");
	motor_busy_a: assert property (code != 3'h0 |-> busy_o || $past(busy_o))
		else $error("motor driven while idle");
	class_cause_a: assert property ($changed(disc_class_ff_o) |-> $past(win_b_i, 3)
		|| $past(win_b_i, 4) || $past(elevate_req_i) || $past(elevate_req_i, 2))
		else $error("class changed outside window");
	nudge_c: cover property (nrun_ff && code == 3'h0);
	small_c: cover property (disc_class_ff_o == 2'h1);
	tray_c: cover property (code == 3'h5);
endmodule
bind cstm_ctrl cstm_ctrl_props #(.NUDGE_CYC(NUDGE_CYC)) i_props (.ref_clk_i, .srst_i,
	.elevate_req_i, .clamp_done_i, .tray_stopped_i, .win_b_i, .driver_ctrl_line_one_o,
	.driver_ctrl_line_two_o, .driver_ctrl_line_three_o, .driver_ctrl_line_four_o, .busy_o,
	.disc_class_ff_o);

// ===== verification/tb_changer_stage_tray_motor_ctrl.sv
// self-checking bench for cstm_ctrl with a motor and sensor model
// assumes a 10 MHz clock and a short nudge count
`timescale 1ns/1ps
module tb_changer_stage_tray_motor_ctrl;
	localparam [9:0] NCYC = 10'h014;
	reg ref_clk_i = 1'b0;
	reg srst_i = 1'b1;
	reg req = 1'b0;
	reg ej = 1'b0;
	reg sn = 1'b1;
	reg wa = 1'b0;
	reg wb = 1'b0;
	reg [9:0] tgt = 10'h200;
	wire [9:0] pos;
	wire cd, ts, tip, th, l1, l2, l3, l4, busy;
	wire [1:0] cls;
	wire [2:0] code = {l1, l2, l4};
	integer err_count = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer i, k;
	always #50 ref_clk_i = ~ref_clk_i;
	cstm_ctrl #(.NUDGE_CYC(NCYC)) i_dut (.ref_clk_i, .srst_i, .elevate_req_i(req),
		.target_pos_i(tgt), .eject_req_i(ej), .stage_position_voltage_i(pos), .clamp_done_i(cd),
		.tray_stopped_i(ts), .tray_in_place_i(tip), .tray_home_i(th), .disc_sense_i(sn),
		.win_a_i(wa), .win_b_i(wb), .driver_ctrl_line_one_o(l1), .driver_ctrl_line_two_o(l2),
		.driver_ctrl_line_three_o(l3), .driver_ctrl_line_four_o(l4), .busy_o(busy),
		.disc_class_ff_o(cls));
	cstm_motor_model i_model (.ref_clk_i, .srst_i, .code_i(code), .pos_o(pos), .clamp_o(cd),
		.stop_o(ts), .in_place_o(tip), .home_o(th));
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input [9:0] got, input [9:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task step(input integer n);
		begin
			repeat (n) @(posedge ref_clk_i);
			#10;
		end
	endtask
	task wcode(input [2:0] c);
		for (k = 0; code !== c && k < 3000; k = k + 1) step(1);
	endtask
	// one window; a forced low sample mid-window, the rest random when low is wanted
	task win(input b, input lo);
		begin
			for (k = 0; k < 6; k = k + 1) begin
				wa = !b;
				wb = b;
				sn = lo ? (k != 3) & $urandom : 1'b1;
				step(1);
			end
			wa = 1'b0;
			wb = 1'b0;
			sn = 1'b1;
			step(3);
		end
	endtask
	function [9:0] near(input [9:0] a, input [9:0] b);
		near = {9'h000, (a > b ? a - b : b - a) <= 10'h002};
	endfunction
	always @(posedge ref_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			close_out;
		end
	end
	initial begin
		k = $urandom(32'h213E);
		step(6);
		srst_i = 1'b0;
		step(1);
		chk({7'h00, code}, 10'h000);
		chk({8'h00, cls}, 10'h002);
		for (i = 0; i < 4; i = i + 1) begin
			tgt = 10'h064 + $urandom % 800;
			req = 1'b1;
			step(1);
			req = 1'b0;
			wcode(3'h2);
			chk({7'h00, code}, 10'h002);
			chk(near(pos, tgt), 10'h001);
			win(1'b0, i[0]);
			win(1'b1, i[1]);
			sn = $urandom;
			wcode(3'h1);
			for (k = 0; code === 3'h1 && k < 99; k = k + 1) step(1);
			chk(k[9:0], NCYC);
			chk({7'h00, code}, 10'h000);
			chk({8'h00, cls}, {9'h000, i == 1});
			chk({9'h000, busy}, 10'h000);
			ej = 1'b1;
			wcode(3'h5);
			chk(near(pos, tgt), 10'h001);
			chk({9'h000, l3}, 10'h001);
			ej = 1'b0;
			for (k = 0; busy !== 1'b0 && k < 99; k = k + 1) step(1);
			chk({9'h000, th}, 10'h001);
			$display("test %0d done", i);
		end
		close_out;
	end
endmodule
